// File: logic/external_pin_interrupt_ctrl.v
`timescale 1ns/100ps
`include "ext_irq_consts.vh"
`default_nettype none

module external_pin_interrupt_ctrl (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Core interface
    input wire global_irq_enable,
    input wire irq_ack,
    input wire [2:0] ack_vector,
    output reg irq_req,
    output reg [2:0] irq_vector,
    // Pads
    input wire ext_irq_pin_a,
    input wire ext_irq_pin_b,
    input wire ext_irq_pin_c,
    input wire [7:0] pinchange_inputs_lower,
    input wire [7:0] pinchange_inputs_upper
);

    // ------------------------------------------------------------
    // Edge or change event for a sampled pin
    // ------------------------------------------------------------
    function sense_event;
        input [1:0] mode;
        input cur;
        input prev;
        begin
            case (mode)
                `SENSE_ANY: sense_event = cur ^ prev;
                `SENSE_FALL: sense_event = prev & ~cur;
                `SENSE_RISE: sense_event = cur & ~prev;
                default: sense_event = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_s1_r;
    reg rst_s2_r;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    wire rst_int_n = rst_s2_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    reg [1:0] pin0_sense_r;
    reg [1:0] pin1_sense_r;
    reg pin2_edge_select_r;
    reg en_pin_a_r;
    reg en_pin_b_r;
    reg en_pin_c_r;
    reg en_group1_r;
    reg en_group0_r;
    reg [7:0] pinchange_mask_upper_r;
    reg [7:0] pinchange_mask_lower_r;

    wire wr_main = reg_wr && (reg_addr == `OFS_MAIN_MCU_CONTROL);
    wire wr_ext = reg_wr && (reg_addr == `OFS_EXTENDED_MCU_CONTROL);
    wire wr_gic = reg_wr && (reg_addr == `OFS_GENERAL_INTERRUPT_CONTROL);
    wire wr_flags = reg_wr && (reg_addr == `OFS_GENERAL_INTERRUPT_FLAGS);
    wire wr_mask_up = reg_wr && (reg_addr == `OFS_PINCHANGE_MASK_UPPER);
    wire wr_mask_lo = reg_wr && (reg_addr == `OFS_PINCHANGE_MASK_LOWER);

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pin0_sense_r <= `RST_SENSE;
            pin1_sense_r <= `RST_SENSE;
            pin2_edge_select_r <= 1'b0;
            en_pin_a_r <= `RST_ENABLE;
            en_pin_b_r <= `RST_ENABLE;
            en_pin_c_r <= `RST_ENABLE;
            en_group1_r <= `RST_ENABLE;
            en_group0_r <= `RST_ENABLE;
            pinchange_mask_upper_r <= `RST_MASK;
            pinchange_mask_lower_r <= `RST_MASK;
        end else begin
            if (wr_main) begin
                pin0_sense_r <= {reg_wdata[`POS_PIN0_SENSE_HI],
                    reg_wdata[`POS_PIN0_SENSE_LO]};
                pin1_sense_r <= {reg_wdata[`POS_PIN1_SENSE_HI],
                    reg_wdata[`POS_PIN1_SENSE_LO]};
            end
            if (wr_ext) begin
                pin2_edge_select_r <= reg_wdata[`POS_PIN2_EDGE_SELECT];
            end
            if (wr_gic) begin
                en_pin_b_r <= reg_wdata[`POS_EN_PIN_B];
                en_pin_a_r <= reg_wdata[`POS_EN_PIN_A];
                en_pin_c_r <= reg_wdata[`POS_EN_PIN_C];
                en_group1_r <= reg_wdata[`POS_EN_GROUP1];
                en_group0_r <= reg_wdata[`POS_EN_GROUP0];
            end
            if (wr_mask_up) begin
                pinchange_mask_upper_r <= reg_wdata;
            end
            if (wr_mask_lo) begin
                pinchange_mask_lower_r <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin A and B sampling
    // ------------------------------------------------------------
    reg a_s1_r;
    reg a_s2_r;
    reg a_s3_r;
    reg b_s1_r;
    reg b_s2_r;
    reg b_s3_r;

    // Pad value is sampled whatever the pin direction
    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            a_s1_r <= 1'b1;
            a_s2_r <= 1'b1;
            a_s3_r <= 1'b1;
            b_s1_r <= 1'b1;
            b_s2_r <= 1'b1;
            b_s3_r <= 1'b1;
        end else begin
            a_s1_r <= ext_irq_pin_a;
            a_s2_r <= a_s1_r;
            a_s3_r <= a_s2_r;
            b_s1_r <= ext_irq_pin_b;
            b_s2_r <= b_s1_r;
            b_s3_r <= b_s2_r;
        end
    end

    wire level_a = (pin0_sense_r == `SENSE_LOW);
    wire level_b = (pin1_sense_r == `SENSE_LOW);
    wire ev_a = sense_event(pin0_sense_r, a_s2_r, a_s3_r);
    wire ev_b = sense_event(pin1_sense_r, b_s2_r, b_s3_r);

    // ------------------------------------------------------------
    // Pin C capture without the clock
    // ------------------------------------------------------------
    reg c_tog_r;
    reg c_t1_r;
    reg c_t2_r;
    reg c_t3_r;

    // Rewriting the select flips this line and can count as an edge
    wire c_edge_clk = ext_irq_pin_c ~^ pin2_edge_select_r;

    always @(posedge c_edge_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            c_tog_r <= 1'b0;
        end else begin
            c_tog_r <= ~c_tog_r;
        end
    end

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            c_t1_r <= 1'b0;
            c_t2_r <= 1'b0;
            c_t3_r <= 1'b0;
        end else begin
            c_t1_r <= c_tog_r;
            c_t2_r <= c_t1_r;
            c_t3_r <= c_t2_r;
        end
    end

    wire ev_c = c_t2_r ^ c_t3_r;

    // ------------------------------------------------------------
    // Pin change sampling
    // ------------------------------------------------------------
    reg [15:0] pc_s1_r;
    reg [15:0] pc_s2_r;
    reg [15:0] pc_s3_r;

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pc_s1_r <= 16'h0000;
            pc_s2_r <= 16'h0000;
            pc_s3_r <= 16'h0000;
        end else begin
            pc_s1_r <= {pinchange_inputs_upper, pinchange_inputs_lower};
            pc_s2_r <= pc_s1_r;
            pc_s3_r <= pc_s2_r;
        end
    end

    wire [15:0] pc_change = pc_s2_r ^ pc_s3_r;
    wire ev_g1 = |(pc_change[15:8] & pinchange_mask_upper_r);
    wire ev_g0 = |(pc_change[7:0] & pinchange_mask_lower_r);

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    reg flag_a_r;
    reg flag_b_r;
    reg flag_c_r;
    reg flag_g1_r;
    reg flag_g0_r;
    wire ack_a = irq_ack && (ack_vector == `VEC_PIN_A);
    wire ack_b = irq_ack && (ack_vector == `VEC_PIN_B);
    wire ack_c = irq_ack && (ack_vector == `VEC_PIN_C);
    wire ack_g0 = irq_ack && (ack_vector == `VEC_GROUP0);
    wire ack_g1 = irq_ack && (ack_vector == `VEC_GROUP1);

    // New events win over a clear in the same cycle
    wire flag_a_nxt = level_a ? 1'b0 : (ev_a | (flag_a_r &
        ~((wr_flags & reg_wdata[`POS_FLAG_PIN_A]) | ack_a)));
    wire flag_b_nxt = level_b ? 1'b0 : (ev_b | (flag_b_r &
        ~((wr_flags & reg_wdata[`POS_FLAG_PIN_B]) | ack_b)));
    wire flag_c_nxt = ev_c | (flag_c_r &
        ~((wr_flags & reg_wdata[`POS_FLAG_PIN_C]) | ack_c));
    wire flag_g1_nxt = ev_g1 | (flag_g1_r &
        ~((wr_flags & reg_wdata[`POS_FLAG_GROUP1]) | ack_g1));
    wire flag_g0_nxt = ev_g0 | (flag_g0_r &
        ~((wr_flags & reg_wdata[`POS_FLAG_GROUP0]) | ack_g0));

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
            flag_c_r <= 1'b0;
            flag_g1_r <= 1'b0;
            flag_g0_r <= 1'b0;
        end else begin
            flag_a_r <= flag_a_nxt;
            flag_b_r <= flag_b_nxt;
            flag_c_r <= flag_c_nxt;
            flag_g1_r <= flag_g1_nxt;
            flag_g0_r <= flag_g0_nxt;
        end
    end

    // ------------------------------------------------------------
    // Request and vector
    // ------------------------------------------------------------
    reg irq_req_nxt;
    reg [2:0] irq_vector_nxt;

    // Built from next flag values so the request drops with the flag
    wire pend_a = en_pin_a_r & global_irq_enable &
        (level_a ? ~a_s2_r : flag_a_nxt);
    wire pend_b = en_pin_b_r & global_irq_enable &
        (level_b ? ~b_s2_r : flag_b_nxt);
    wire pend_c = en_pin_c_r & global_irq_enable & flag_c_nxt;
    wire pend_g1 = en_group1_r & global_irq_enable & flag_g1_nxt;
    wire pend_g0 = en_group0_r & global_irq_enable & flag_g0_nxt;

    always @* begin
        irq_req_nxt = pend_a | pend_b | pend_c | pend_g0 | pend_g1;
        irq_vector_nxt = `VEC_PIN_A;
        if (pend_a) begin
            irq_vector_nxt = `VEC_PIN_A;
        end else if (pend_b) begin
            irq_vector_nxt = `VEC_PIN_B;
        end else if (pend_c) begin
            irq_vector_nxt = `VEC_PIN_C;
        end else if (pend_g0) begin
            irq_vector_nxt = `VEC_GROUP0;
        end else if (pend_g1) begin
            irq_vector_nxt = `VEC_GROUP1;
        end
    end

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            irq_req <= 1'b0;
            irq_vector <= `VEC_PIN_A;
        end else begin
            irq_req <= irq_req_nxt;
            irq_vector <= irq_vector_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = `RST_BYTE;
        case (reg_addr)
            `OFS_MAIN_MCU_CONTROL: begin
                rd_mux[`POS_PIN1_SENSE_HI] = pin1_sense_r[1];
                rd_mux[`POS_PIN1_SENSE_LO] = pin1_sense_r[0];
                rd_mux[`POS_PIN0_SENSE_HI] = pin0_sense_r[1];
                rd_mux[`POS_PIN0_SENSE_LO] = pin0_sense_r[0];
            end
            `OFS_EXTENDED_MCU_CONTROL: rd_mux[`POS_PIN2_EDGE_SELECT] = pin2_edge_select_r;
            `OFS_GENERAL_INTERRUPT_CONTROL: begin
                rd_mux[`POS_EN_PIN_B] = en_pin_b_r;
                rd_mux[`POS_EN_PIN_A] = en_pin_a_r;
                rd_mux[`POS_EN_PIN_C] = en_pin_c_r;
                rd_mux[`POS_EN_GROUP1] = en_group1_r;
                rd_mux[`POS_EN_GROUP0] = en_group0_r;
            end
            `OFS_GENERAL_INTERRUPT_FLAGS: begin
                rd_mux[`POS_FLAG_PIN_B] = flag_b_r;
                rd_mux[`POS_FLAG_PIN_A] = flag_a_r;
                rd_mux[`POS_FLAG_PIN_C] = flag_c_r;
                rd_mux[`POS_FLAG_GROUP1] = flag_g1_r;
                rd_mux[`POS_FLAG_GROUP0] = flag_g0_r;
            end
            `OFS_PINCHANGE_MASK_UPPER: rd_mux = pinchange_mask_upper_r;
            `OFS_PINCHANGE_MASK_LOWER: rd_mux = pinchange_mask_lower_r;
            default: rd_mux = `RST_BYTE;
        endcase
    end

    always @(posedge core_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            reg_rdata <= `RST_BYTE;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : `RST_BYTE;
        end
    end

endmodule // external_pin_interrupt_ctrl

`default_nettype wire

// File: shared/ext_irq_consts.vh
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH

// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define OFS_MAIN_MCU_CONTROL 4'h0
`define OFS_EXTENDED_MCU_CONTROL 4'h1
`define OFS_GENERAL_INTERRUPT_CONTROL 4'h2
`define OFS_GENERAL_INTERRUPT_FLAGS 4'h3
`define OFS_PINCHANGE_MASK_UPPER 4'h4
`define OFS_PINCHANGE_MASK_LOWER 4'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_PIN0_SENSE_LO 0
`define POS_PIN0_SENSE_HI 1
`define POS_PIN1_SENSE_LO 2
`define POS_PIN1_SENSE_HI 3
`define POS_PIN2_EDGE_SELECT 0
`define POS_EN_PIN_B 7
`define POS_EN_PIN_A 6
`define POS_EN_PIN_C 5
`define POS_EN_GROUP1 4
`define POS_EN_GROUP0 3
`define POS_FLAG_PIN_B 7
`define POS_FLAG_PIN_A 6
`define POS_FLAG_PIN_C 5
`define POS_FLAG_GROUP1 4
`define POS_FLAG_GROUP0 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SENSE 2'h0
`define RST_ENABLE 1'h0
`define RST_MASK 8'h00
`define RST_BYTE 8'h00

// ----------------------------------------------------------------
// Sense modes
// ----------------------------------------------------------------
`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

// ----------------------------------------------------------------
// Vector codes
// ----------------------------------------------------------------
`define VEC_PIN_A 3'h0
`define VEC_PIN_B 3'h1
`define VEC_PIN_C 3'h2
`define VEC_GROUP0 3'h3
`define VEC_GROUP1 3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define PIN_C_MIN_PULSE_NS 50
`define PIN_C_MIN_PULSE_CYC ((`PIN_C_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: testbench/ext_irq_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_consts.vh"
module ext_irq_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Core side
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [2:0] irq_vector
);
// ----------------
// Enable shadow
// ----------------
logic [7:0] en_sh_r;

always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        en_sh_r <= 8'h00;
    end else if (reg_wr && reg_addr == `OFS_GENERAL_INTERRUPT_CONTROL) begin
        en_sh_r <= reg_wdata;
    end
end

default clocking cb @(posedge core_clk); endclocking
default disable iff (!rst_n);

// ----------------
// Properties
// ----------------
// Enable may change one edge before the request follows
pin_a_gate_a:
    assert property (irq_req && irq_vector == `VEC_PIN_A |-> en_sh_r[6] || $past(en_sh_r[6]))
    else $error("pin a request while disabled");
pin_b_gate_a:
    assert property (irq_req && irq_vector == `VEC_PIN_B |-> en_sh_r[7] || $past(en_sh_r[7]))
    else $error("pin b request while disabled");
pin_c_gate_a:
    assert property (irq_req && irq_vector == `VEC_PIN_C |-> en_sh_r[5] || $past(en_sh_r[5]))
    else $error("pin c request while disabled");
group1_gate_a:
    assert property (irq_req && irq_vector == `VEC_GROUP1 |-> en_sh_r[4] || $past(en_sh_r[4]))
    else $error("group 1 request while disabled");
group0_gate_a:
    assert property (irq_req && irq_vector == `VEC_GROUP0 |-> en_sh_r[3] || $past(en_sh_r[3]))
    else $error("group 0 request while disabled");
global_gate_a:
    assert property (!global_irq_enable [*2] |=> !irq_req)
    else $error("request with global enable low");
vector_range_a:
    assert property (irq_req |-> irq_vector <= `VEC_GROUP1)
    else $error("vector out of range");
hold_req_a:
    assert property (irq_req && irq_vector >= `VEC_PIN_C && !irq_ack && !reg_wr
        && global_irq_enable && $past(global_irq_enable) |=> irq_req)
    else $error("flagged request dropped without ack");
endmodule // ext_irq_props

bind external_pin_interrupt_ctrl ext_irq_props i_props (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .global_irq_enable(global_irq_enable),
    .irq_ack(irq_ack),
    .irq_req(irq_req),
    .irq_vector(irq_vector)
);
`default_nettype wire

// File: testbench/ext_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pin_source (
    // Clock
    input wire logic core_clk,
    // Pads
    output logic pin_a,
    output logic pin_b,
    output logic pin_c,
    output logic [7:0] pc_lo,
    output logic [7:0] pc_hi
);
// ----------------
// Pad drivers
// ----------------
initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
    pin_c = 1'b1;
    pc_lo = 8'h00;
    pc_hi = 8'h00;
end

// Levels held by caller for whole cycles, never sub-clock glitches
task automatic set_pin(input int p, input logic v);
    @(posedge core_clk);
    case (p)
        0: pin_a <= v;
        1: pin_b <= v;
        default: pin_c <= v;
    endcase
endtask

task automatic flip(input int g, input int b);
    @(posedge core_clk);
    if (g != 0) begin
        pc_hi[b] <= ~pc_hi[b];
    end else begin
        pc_lo[b] <= ~pc_lo[b];
    end
endtask
endmodule // ext_pin_source
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_consts.vh"
module tb;
// ----------------
// Signals
// ----------------
logic core_clk;
logic rst_n;
logic [3:0] reg_addr;
logic [7:0] reg_wdata;
logic reg_wr;
logic reg_rd;
logic gie;
logic irq_ack;
logic [2:0] ack_vector;
wire [7:0] reg_rdata;
wire irq_req;
wire [2:0] irq_vector;
wire pin_a;
wire pin_b;
wire pin_c;
wire [7:0] pc_lo;
wire [7:0] pc_hi;
int fail_count = 0;
int checked = 0;
int cycles = 0;

external_pin_interrupt_ctrl i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .global_irq_enable(gie),
    .irq_ack(irq_ack),
    .ack_vector(ack_vector),
    .irq_req(irq_req),
    .irq_vector(irq_vector),
    .ext_irq_pin_a(pin_a),
    .ext_irq_pin_b(pin_b),
    .ext_irq_pin_c(pin_c),
    .pinchange_inputs_lower(pc_lo),
    .pinchange_inputs_upper(pc_hi)
);

ext_pin_source i_pins (
    .core_clk(core_clk),
    .pin_a(pin_a),
    .pin_b(pin_b),
    .pin_c(pin_c),
    .pc_lo(pc_lo),
    .pc_hi(pc_hi)
);

// ----------------
// Helpers
// ----------------
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
        fail_count++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask

task automatic chk_irq(input logic e, input logic [2:0] v);
    chk({4'h0, irq_req, irq_vector}, {4'h0, e, e ? v : 3'h0});
endtask

task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
endtask

task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
endtask

task automatic ack(input logic [2:0] v);
    @(posedge core_clk);
    irq_ack <= 1'b1;
    ack_vector <= v;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    #1;
endtask

task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask

// ----------------
// Scenarios
// ----------------
task automatic t_regs;
    logic [7:0] rb [0:5];
    rb = '{8'h0f, 8'h01, 8'hf8, 8'h00, 8'hff, 8'hff};
    // Flags read before the edge select is touched
    for (int a = 5; a >= 0; a--) begin
        rdc(4'(a), 8'h00);
        wr(4'(a), 8'hff);
        rdc(4'(a), rb[a]);
        wr(4'(a), 8'h00);
    end
    wr(4'h9, 8'hff);
    rdc(4'h9, 8'h00);
    settle(6);
    wr(`OFS_GENERAL_INTERRUPT_FLAGS, 8'hff);
    $display("regs done");
endtask

task automatic edge_step(input int p, input logic v, input logic e);
    i_pins.set_pin(p, v);
    settle(4);
    rdc(`OFS_GENERAL_INTERRUPT_FLAGS, e ? 8'h40 << p : 8'h00);
    chk_irq(e, 3'(p));
    ack(3'(p));
    chk_irq(1'b0, 3'h0);
endtask

task automatic t_edges;
    @(posedge core_clk);
    gie <= 1'b1;
    for (int p = 0; p < 2; p++) begin
        wr(`OFS_GENERAL_INTERRUPT_CONTROL, 8'h40 << p);
        for (int m = 1; m < 4; m++) begin
            wr(`OFS_MAIN_MCU_CONTROL, 8'(m << (2 * p)));
            edge_step(p, 1'b0, m != 3);
            edge_step(p, 1'b1, m != 2);
        end
    end
    $display("edges done");
endtask

task automatic t_level;
    wr(`OFS_MAIN_MCU_CONTROL, 8'h00);
    for (int p = 0; p < 2; p++) begin
        wr(`OFS_GENERAL_INTERRUPT_CONTROL, 8'h40 << p);
        i_pins.set_pin(p, 1'b0);
        settle(4);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h00);
        chk_irq(1'b1, 3'(p));
        ack(3'(p));
        chk_irq(1'b1, 3'(p));
        i_pins.set_pin(p, 1'b1);
        settle(4);
        chk_irq(1'b0, 3'h0);
    end
    $display("level done");
endtask

task automatic t_pin_c;
    for (int s = 0; s < 2; s++) begin
        i_pins.set_pin(2, 1'(s));
        wr(`OFS_GENERAL_INTERRUPT_CONTROL, 8'h00);
        wr(`OFS_EXTENDED_MCU_CONTROL, 8'(s));
        settle(6);
        wr(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h20);
        wr(`OFS_GENERAL_INTERRUPT_CONTROL, 8'h20);
        i_pins.set_pin(2, ~1'(s));
        settle(8);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h00);
        i_pins.set_pin(2, 1'(s));
        settle(8);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h20);
        chk_irq(1'b1, `VEC_PIN_C);
        ack(`VEC_PIN_C);
        chk_irq(1'b0, 3'h0);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h00);
    end
    $display("pin c done");
endtask

task automatic t_pinchange;
    logic [7:0] fb;
    for (int g = 0; g < 2; g++) begin
        fb = 8'h08 << g;
        @(posedge core_clk);
        gie <= 1'b0;
        wr(g ? `OFS_PINCHANGE_MASK_UPPER : `OFS_PINCHANGE_MASK_LOWER, 8'h08);
        wr(`OFS_GENERAL_INTERRUPT_CONTROL, fb);
        i_pins.flip(g, 5);
        settle(4);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, 8'h00);
        i_pins.flip(g, 3);
        settle(4);
        rdc(`OFS_GENERAL_INTERRUPT_FLAGS, fb);
        chk_irq(1'b0, 3'h0);
        @(posedge core_clk);
        gie <= 1'b1;
        settle(2);
        chk_irq(1'b1, 3'(3 + g));
        wr(`OFS_GENERAL_INTERRUPT_FLAGS, fb);
        chk_irq(1'b0, 3'h0);
    end
    $display("pin change done");
endtask

task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
        $display("DONE - PASS");
    end else begin
        $display("DONE - FAIL");
    end
    $finish;
endtask

// ----------------
// Clock, watchdog, sequence
// ----------------
initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
end

always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
        fail_count++;
        $display("BAD %0t timeout", $time);
        complete_run();
    end
end

initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gie = 1'b0;
    irq_ack = 1'b0;
    ack_vector = 3'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_edges();
    t_level();
    t_pin_c();
    t_pinchange();
    complete_run();
end
endmodule // tb
`default_nettype wire
